// >>> verilog/pse_pkg.sv
// Shared constants, types and helpers for the fault status and channel remap bank
package pse_pkg;

   localparam int CHANNELS = 4;
   localparam int FIELD_W = 2;
   localparam int PAIRS = 2;

   localparam logic [7:0] CMD_FAULT_RO = 8'h24;
   localparam logic [7:0] CMD_FAULT_COR = 8'h25;
   localparam logic [7:0] CMD_REMAP = 8'h26;

   localparam logic [7:0] FAULT_RESET = 8'h00;
   localparam logic [7:0] REMAP_RESET = 8'he4;
   localparam logic [7:0] READ_UNMAPPED = 8'h00;

   localparam logic [1:0] FC_NONE = 2'h0;
   localparam logic [1:0] FC_DETECT = 2'h1;
   localparam logic [1:0] FC_CLASS = 2'h2;
   localparam logic [1:0] FC_POWER = 2'h3;

   typedef enum logic [0:0] {
      RD_IDLE = 1'b0,
      RD_COR_PENDING = 1'b1
   } rd_state_t;

   typedef struct packed {
      logic turn_on_fail;
      logic start_fault;
      logic [1:0] cause;
      logic class_enable;
      logic power_denied;
      logic switched_off;
   } chan_evt_t;

   typedef struct packed {
      logic four_pair;
      logic single_sig;
   } pair_cfg_t;

   typedef struct packed {
      logic valid;
      logic write;
      logic [7:0] code;
      logic [7:0] wdata;
   } cmd_t;

   // True when all four physical codes in a remap byte are distinct
   function automatic logic remap_unique(input logic [7:0] v);
      logic ok;
      ok = 1'b1;
      for (int a = 0; a < CHANNELS; a++)
      begin
         for (int b = a + 1; b < CHANNELS; b++)
         begin
            if (v[a*FIELD_W +: FIELD_W] == v[b*FIELD_W +: FIELD_W])
            begin
               ok = 1'b0;
            end
         end
      end
      return ok;
   endfunction

   // Returns {set, code} for one channel's events this cycle
   function automatic logic [2:0] chan_set(input chan_evt_t e);
      logic [2:0] r;
      r = {1'b0, FC_NONE};
      if (e.power_denied)
      begin
         r = {1'b1, FC_POWER};
      end
      else if (e.turn_on_fail)
      begin
         r = {1'b1, e.cause};
      end
      else if (e.start_fault && !e.class_enable)
      begin
         r = {1'b1, e.cause};
      end
      return r;
   endfunction

endpackage

// >>> verilog/remap_store.sv
// Channel remap register reset only by power-on reset, with duplicate-code rejection
`timescale 1ns/1ps
module remap_store
(
   input wire logic ref_clk_i,
   input wire logic por_n_i,
   input wire logic wr_i,
   input wire logic [7:0] wdata_i,
   output logic [7:0] remap_o,
   output logic reject_o
);
   import pse_pkg::*;

   logic [7:0] remap_r;
   logic [7:0] remap_nxt;
   logic reject_r;
   wire accept = wr_i && remap_unique(wdata_i);

   // Device reset pin is deliberately not an input here
   assign remap_nxt = accept ? wdata_i : remap_r;

   always_ff @(posedge ref_clk_i)
   begin
      if (!por_n_i)
      begin
         remap_r <= REMAP_RESET;
         reject_r <= 1'b0;
      end
      else
      begin
         remap_r <= remap_nxt;
         reject_r <= wr_i && !accept;
      end
   end

   assign remap_o = remap_r;
   assign reject_o = reject_r;

   ////////////////////////////////////////////////////////////////////////////////
   property p_dup_keeps;
      @(posedge ref_clk_i) disable iff (!por_n_i)
      (wr_i && !remap_unique(wdata_i)) |=> (remap_r == $past(remap_r)) && reject_r;
   endproperty
   a_dup_keeps: assert property (p_dup_keeps) else $error("Duplicate remap write altered map");

   property p_por_default;
      @(posedge ref_clk_i) !por_n_i |=> remap_r == REMAP_RESET;
   endproperty
   a_por_default: assert property (p_por_default) else $error("Remap not default after power-on");

endmodule // remap_store

// >>> verilog/pse_fault_and_port_remap.sv
// Power-on fault status and channel remap register bank for one four-channel group
`timescale 1ns/1ps
module pse_fault_and_port_remap
#(
   parameter int CHANNELS_P = 4
)
(
   input wire logic ref_clk_i,
   input wire logic rst_n_i,
   input wire logic por_n_i,
   input wire pse_pkg::cmd_t cmd_i,
   input wire logic rd_done_i,
   input wire pse_pkg::chan_evt_t [3:0] chan_evt_i,
   input wire pse_pkg::pair_cfg_t [1:0] pair_cfg_i,
   output logic cmd_ack_o,
   output logic [7:0] rd_data_o,
   output logic [7:0] fault_o,
   output logic [7:0] remap_o,
   output logic remap_reject_o
);
   import pse_pkg::*;

   if (CHANNELS_P != CHANNELS)
   begin : g_bad_channels
      $error("Bank serves exactly one group of four channels");
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Command decode

   logic [7:0] fault_r;
   logic [7:0] fault_nxt;
   logic [CHANNELS-1:0] touched_r;
   logic [CHANNELS-1:0] touched_nxt;
   logic [7:0] rd_data_r;
   logic [7:0] rd_data_nxt;
   logic [7:0] remap_w;
   logic [7:0] read_sel;
   rd_state_t rd_state_r;
   rd_state_t rd_state_nxt;

   wire hit_ro = cmd_i.code == CMD_FAULT_RO;
   wire hit_cor = cmd_i.code == CMD_FAULT_COR;
   wire hit_remap = cmd_i.code == CMD_REMAP;
   wire hit_any = hit_ro || hit_cor || hit_remap;
   wire rd_take = cmd_i.valid && !cmd_i.write && hit_any;
   wire cor_take = cmd_i.valid && !cmd_i.write && hit_cor;
   // Writes to the fault codes are acknowledged but otherwise ignored
   wire remap_wr = cmd_i.valid && cmd_i.write && hit_remap;
   wire cor_fire = (rd_state_r == RD_COR_PENDING) && rd_done_i;

   assign cmd_ack_o = cmd_i.valid && hit_any;
   assign read_sel = (hit_ro || hit_cor) ? fault_r : (hit_remap ? remap_w : READ_UNMAPPED);
   assign rd_data_nxt = rd_take ? read_sel : rd_data_r;

   ////////////////////////////////////////////////////////////////////////////////
   // Clear-on-read sequencing

   always_comb
   begin
      rd_state_nxt = rd_state_r;
      case (rd_state_r)
         RD_IDLE:
         begin
            if (cor_take)
            begin
               rd_state_nxt = RD_COR_PENDING;
            end
         end
         RD_COR_PENDING:
         begin
            if (rd_done_i)
            begin
               rd_state_nxt = RD_IDLE;
            end
         end
         default:
         begin
            rd_state_nxt = RD_IDLE;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Per-channel fault update

   logic [2:0] own_set [CHANNELS];
   logic [2:0] eff_set [CHANNELS];

   for (genvar c = 0; c < CHANNELS; c++)
   begin : g_chan
      localparam int PAIR = c / 2;
      localparam int LEAD = PAIR * 2;
      localparam int TRAIL = LEAD + 1;
      wire joint = pair_cfg_i[PAIR].four_pair && pair_cfg_i[PAIR].single_sig;
      wire [1:0] cur = fault_r[c*FIELD_W +: FIELD_W];
      wire trail_pwr = own_set[TRAIL][2] && (own_set[TRAIL][1:0] == FC_POWER);
      assign own_set[c] = chan_set(chan_evt_i[c]);
      // Single signature: one code chosen per pair so a new fault sets both halves alike; denial wins
      assign eff_set[c] = !joint ? own_set[c] :
                          ((trail_pwr || !own_set[LEAD][2]) ? own_set[TRAIL] : own_set[LEAD]);
      // Any move of a field after the snapshot shields it, even to the same code
      wire ev = eff_set[c][2] || chan_evt_i[c].switched_off;
      assign touched_nxt[c] = (rd_state_r == RD_COR_PENDING) ? (touched_r[c] || ev) : (cor_take && ev);
      // An event in the same cycle as a switch-off or clear-on-read clear wins over it; reset wins over an event
      assign fault_nxt[c*FIELD_W +: FIELD_W] =
         eff_set[c][2] ? eff_set[c][1:0] :
         chan_evt_i[c].switched_off ? FC_NONE :
         (cor_fire && !touched_r[c]) ? FC_NONE :
         cur;
   end

   always_ff @(posedge ref_clk_i)
   begin
      if (!rst_n_i)
      begin
         fault_r <= FAULT_RESET;
         touched_r <= '0;
         rd_data_r <= READ_UNMAPPED;
         rd_state_r <= RD_IDLE;
      end
      else
      begin
         fault_r <= fault_nxt;
         touched_r <= touched_nxt;
         rd_data_r <= rd_data_nxt;
         rd_state_r <= rd_state_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Remap register; a two-bit code can only name a channel of this group

   remap_store u_remap
   (
      .ref_clk_i(ref_clk_i),
      .por_n_i(por_n_i),
      .wr_i(remap_wr), // Host quiesces the group first
      .wdata_i(cmd_i.wdata),
      .remap_o(remap_w),
      .reject_o(remap_reject_o)
   );

   assign rd_data_o = rd_data_r;
   assign fault_o = fault_r;
   assign remap_o = remap_w;

   ////////////////////////////////////////////////////////////////////////////////
   // Checks

   wire any_set = own_set[0][2] || own_set[1][2] || own_set[2][2] || own_set[3][2];
   wire any_off = chan_evt_i[0].switched_off || chan_evt_i[1].switched_off ||
                  chan_evt_i[2].switched_off || chan_evt_i[3].switched_off;
   wire quiet = !any_set && !any_off;
   wire solo0 = !(pair_cfg_i[0].four_pair && pair_cfg_i[0].single_sig);

   property p_ro_read;
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      (cmd_i.valid && !cmd_i.write && hit_ro && quiet && !cor_fire) |=>
         (rd_data_o == $past(fault_r)) && (fault_r == $past(fault_r));
   endproperty
   a_ro_read: assert property (p_ro_read) else $error("Plain fault read disturbed the fields");

   property p_cor_clear;
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      (cor_take && rd_state_r == RD_IDLE && quiet) ##1 (quiet && rd_done_i) |=> fault_r == FAULT_RESET;
   endproperty
   a_cor_clear: assert property (p_cor_clear) else $error("Clear-on-read left fault bits set");

   property p_turn_on_cause;
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      (chan_evt_i[0].turn_on_fail && !chan_evt_i[0].power_denied && solo0) |=>
         fault_r[1:0] == $past(chan_evt_i[0].cause);
   endproperty
   a_turn_on_cause: assert property (p_turn_on_cause) else $error("Turn-on failure cause not recorded");

   property p_off_clear;
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      (chan_evt_i[2].switched_off && !eff_set[2][2]) |=> fault_r[5:4] == FC_NONE;
   endproperty
   a_off_clear: assert property (p_off_clear) else $error("Switch-off did not clear fault code");

   property p_start_fault;
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      (chan_evt_i[3].start_fault && !chan_evt_i[3].class_enable && !chan_evt_i[3].turn_on_fail &&
       !chan_evt_i[3].power_denied && !(pair_cfg_i[1].four_pair && pair_cfg_i[1].single_sig)) |=>
         fault_r[7:6] == $past(chan_evt_i[3].cause);
   endproperty
   a_start_fault: assert property (p_start_fault) else $error("Start fault cause not recorded");

   property p_denied;
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      chan_evt_i[1].power_denied [*2] |=> fault_r[3:2] == FC_POWER;
   endproperty
   a_denied: assert property (p_denied) else $error("Power denial not reported");

   property p_single_sig;
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      (pair_cfg_i[0].four_pair && pair_cfg_i[0].single_sig && (own_set[0][2] || own_set[1][2])) |=>
         fault_r[1:0] == fault_r[3:2];
   endproperty
   a_single_sig: assert property (p_single_sig) else $error("Single signature halves diverged");

   property p_dual_sig;
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      (solo0 && own_set[0][2] && !own_set[1][2] && !chan_evt_i[1].switched_off && !cor_fire) |=>
         fault_r[3:2] == $past(fault_r[3:2]);
   endproperty
   a_dual_sig: assert property (p_dual_sig) else $error("Dual signature mate was disturbed");

   property p_late_fault_kept;
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      (rd_state_r == RD_COR_PENDING && own_set[0][2] && solo0 && !rd_done_i) ##1
         (rd_done_i && quiet) |=> fault_r[1:0] == $past(fault_r[1:0]);
   endproperty
   a_late_fault_kept: assert property (p_late_fault_kept) else $error("Fault raised during read was lost");

   property p_remap_write;
      @(posedge ref_clk_i) disable iff (!por_n_i)
      (remap_wr && remap_unique(cmd_i.wdata)) |=> remap_o == $past(cmd_i.wdata);
   endproperty
   a_remap_write: assert property (p_remap_write) else $error("Valid remap write not stored");

   property p_pin_reset_keeps;
      @(posedge ref_clk_i) disable iff (!por_n_i)
      (!rst_n_i && !remap_wr) |=> remap_o == $past(remap_o);
   endproperty
   a_pin_reset_keeps: assert property (p_pin_reset_keeps) else $error("Reset pin altered remap");

   property p_cor_data;
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      cor_take |=> rd_data_o == $past(fault_r);
   endproperty
   a_cor_data: assert property (p_cor_data) else $error("Clear-on-read byte wrong");

   property p_remap_read;
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      (rd_take && hit_remap) |=> rd_data_o == $past(remap_w);
   endproperty
   a_remap_read: assert property (p_remap_read) else $error("Remap read byte wrong");

   property p_rd_hold;
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      !rd_take |=> $stable(rd_data_o);
   endproperty
   a_rd_hold: assert property (p_rd_hold) else $error("Read data moved without a read");

   property p_ro_write;
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      (cmd_i.valid && cmd_i.write && (hit_ro || hit_cor) && quiet && !cor_fire) |=> $stable(fault_r);
   endproperty
   a_ro_write: assert property (p_ro_write) else $error("Fault write took effect");

   property p_pair1_shared;
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      (pair_cfg_i[1].four_pair && pair_cfg_i[1].single_sig && (own_set[2][2] || own_set[3][2])) |=>
         fault_r[5:4] == fault_r[7:6];
   endproperty
   a_pair1_shared: assert property (p_pair1_shared) else $error("Upper pair halves diverged");

   property p_hold_quiet;
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      (quiet && !cor_fire) |=> fault_r == $past(fault_r);
   endproperty
   a_hold_quiet: assert property (p_hold_quiet) else $error("Fault field moved without an event");

   property p_reset_clears;
      @(posedge ref_clk_i)
      !rst_n_i |=> (fault_r == FAULT_RESET) && (rd_state_r == RD_IDLE) && (touched_r == '0);
   endproperty
   a_reset_clears: assert property (p_reset_clears) else $error("Reset left fault state");

   property p_denied_ch4;
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      chan_evt_i[3].power_denied |=> fault_r[7:6] == FC_POWER;
   endproperty
   a_denied_ch4: assert property (p_denied_ch4) else $error("Channel four denial not reported");

   property p_remap_keep;
      @(posedge ref_clk_i) disable iff (!por_n_i)
      !remap_wr |=> remap_o == $past(remap_o);
   endproperty
   a_remap_keep: assert property (p_remap_keep) else $error("Remap moved without a write");

   property p_reject_out;
      @(posedge ref_clk_i) disable iff (!por_n_i)
      (remap_wr && !remap_unique(cmd_i.wdata)) |=> remap_reject_o;
   endproperty
   a_reject_out: assert property (p_reject_out) else $error("Duplicate remap write not flagged");

endmodule // pse_fault_and_port_remap

// >>> verif/testbench.sv
// Self-checking bench for the fault status and channel remap bank
`timescale 1ns/1ps
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin failures++; \
   $display("[ERR] %s expected %h seen %h", nm, e, g); end end
module testbench;
   import pse_pkg::*;
   logic ref_clk_i;
   logic rst_n_i;
   logic por_n_i;
   logic rd_done_i;
   logic cmd_ack_o;
   logic remap_reject_o;
   cmd_t cmd_i;
   chan_evt_t [3:0] chan_evt_i;
   pair_cfg_t [1:0] pair_cfg_i;
   logic [7:0] rd_data_o;
   logic [7:0] fault_o;
   logic [7:0] remap_o;
   int failures = 0;
   int num_checks = 0;

   pse_fault_and_port_remap #(.CHANNELS_P(4)) pse_fault_and_port_remap_inst
   (
      .ref_clk_i(ref_clk_i),
      .rst_n_i(rst_n_i),
      .por_n_i(por_n_i),
      .cmd_i(cmd_i),
      .rd_done_i(rd_done_i),
      .chan_evt_i(chan_evt_i),
      .pair_cfg_i(pair_cfg_i),
      .cmd_ack_o(cmd_ack_o),
      .rd_data_o(rd_data_o),
      .fault_o(fault_o),
      .remap_o(remap_o),
      .remap_reject_o(remap_reject_o)
   );

   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      ref_clk_i = 1'b0;
      forever #12.5 ref_clk_i = ~ref_clk_i;
   end

   // Every task starts and ends just after a rising edge, so no input moves twice in one step
   task automatic step;
      @(posedge ref_clk_i);
      #1;
   endtask

   function automatic chan_evt_t mk(input logic tof, input logic sf, input logic [1:0] c,
                                    input logic ce, input logic pd, input logic so);
      return {tof, sf, c, ce, pd, so};
   endfunction

   task automatic access(input logic wr, input logic [7:0] code, input logic [7:0] wd, input logic ack);
      step;
      cmd_i = {1'b1, wr, code, wd};
      #1;
      `CHK("cmd_ack", ack, cmd_ack_o)
      step;
      cmd_i = '0;
   endtask

   task automatic evt(input int ch, input chan_evt_t e);
      step;
      chan_evt_i[ch] = e;
      step;
      chan_evt_i[ch] = '0;
   endtask

   task automatic stop_test;
      $display("checks %0d failures %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_reset_values;
      `CHK("fault after reset", 8'h00, fault_o)
      access(1'b0, CMD_FAULT_RO, 8'h00, 1'b1);
      `CHK("read 24h", 8'h00, rd_data_o)
      access(1'b0, CMD_REMAP, 8'h00, 1'b1);
      `CHK("read 26h", 8'hE4, rd_data_o)
      access(1'b0, 8'h30, 8'h00, 1'b0);
      `CHK("unmapped read", 8'hE4, rd_data_o)
   endtask

   task automatic t_fault_codes;
      evt(0, mk(1'b1, 1'b0, FC_DETECT, 1'b0, 1'b0, 1'b0));
      evt(1, mk(1'b1, 1'b0, FC_CLASS, 1'b0, 1'b0, 1'b0));
      evt(2, mk(1'b0, 1'b1, FC_DETECT, 1'b0, 1'b0, 1'b0));
      // Start fault with classification enabled must leave the field alone
      evt(3, mk(1'b0, 1'b1, FC_CLASS, 1'b1, 1'b0, 1'b0));
      `CHK("fault codes", 8'h19, fault_o)
      evt(3, mk(1'b0, 1'b0, FC_NONE, 1'b0, 1'b1, 1'b0));
      `CHK("power denied", 8'hD9, fault_o)
      access(1'b1, CMD_FAULT_RO, 8'hFF, 1'b1);
      access(1'b0, CMD_FAULT_RO, 8'h00, 1'b1);
      `CHK("read 24h", 8'hD9, rd_data_o)
      access(1'b0, CMD_FAULT_RO, 8'h00, 1'b1);
      `CHK("second read 24h", 8'hD9, rd_data_o)
      `CHK("fault kept", 8'hD9, fault_o)
      evt(2, mk(1'b0, 1'b0, FC_NONE, 1'b0, 1'b0, 1'b1));
      `CHK("channel three off", 8'hC9, fault_o)
   endtask

   task automatic t_clear_on_read;
      access(1'b0, CMD_FAULT_COR, 8'h00, 1'b1);
      `CHK("read 25h", 8'hC9, rd_data_o)
      `CHK("no clear before done", 8'hC9, fault_o)
      // New faults while the byte is in flight, one repeating a code already sent
      evt(1, mk(1'b1, 1'b0, FC_DETECT, 1'b0, 1'b0, 1'b0));
      chan_evt_i[0] = mk(1'b1, 1'b0, FC_DETECT, 1'b0, 1'b0, 1'b0);
      step;
      chan_evt_i[0] = '0;
      rd_done_i = 1'b1;
      step;
      rd_done_i = 1'b0;
      `CHK("cleared but new kept", 8'h05, fault_o)
      evt(1, mk(1'b0, 1'b0, FC_NONE, 1'b0, 1'b0, 1'b1));
      `CHK("switched off", 8'h01, fault_o)
      evt(0, mk(1'b0, 1'b0, FC_NONE, 1'b0, 1'b0, 1'b1));
      `CHK("both off", 8'h00, fault_o)
      // Denial held for two cycles, then dropped
      step;
      chan_evt_i[1] = mk(1'b0, 1'b0, FC_NONE, 1'b0, 1'b1, 1'b0);
      step;
      step;
      chan_evt_i[1] = '0;
      `CHK("denied level", 8'h0C, fault_o)
      evt(1, mk(1'b0, 1'b0, FC_NONE, 1'b0, 1'b0, 1'b1));
      `CHK("denial cleared by off", 8'h00, fault_o)
   endtask

   task automatic t_pairs;
      step;
      pair_cfg_i[0] = 2'b11; // Logical one with two only
      evt(0, mk(1'b1, 1'b0, FC_CLASS, 1'b0, 1'b0, 1'b0));
      `CHK("single signature pair", 8'h0A, fault_o)
      step;
      chan_evt_i[0] = mk(1'b1, 1'b0, FC_DETECT, 1'b0, 1'b0, 1'b0);
      chan_evt_i[1] = mk(1'b1, 1'b0, FC_CLASS, 1'b0, 1'b0, 1'b0);
      step;
      chan_evt_i[0] = '0;
      chan_evt_i[1] = '0;
      `CHK("shared code", 8'h05, fault_o)
      evt(0, mk(1'b0, 1'b0, FC_NONE, 1'b0, 1'b0, 1'b1));
      evt(1, mk(1'b0, 1'b0, FC_NONE, 1'b0, 1'b0, 1'b1));
      step;
      pair_cfg_i[0] = 2'b10;
      evt(1, mk(1'b1, 1'b0, FC_DETECT, 1'b0, 1'b0, 1'b0));
      `CHK("dual signature pair", 8'h04, fault_o)
      evt(1, mk(1'b0, 1'b0, FC_NONE, 1'b0, 1'b0, 1'b1));
      step;
      pair_cfg_i[0] = 2'b00;
   endtask

   task automatic t_remap;
      // Every channel is off by now, so a remap write is allowed
      access(1'b1, CMD_REMAP, 8'h1B, 1'b1);
      `CHK("remap written", 8'h1B, remap_o)
      access(1'b0, CMD_REMAP, 8'h00, 1'b1);
      `CHK("remap read", 8'h1B, rd_data_o)
      access(1'b1, CMD_REMAP, 8'h1A, 1'b1);
      `CHK("reject pulse", 1'b1, remap_reject_o)
      `CHK("map kept", 8'h1B, remap_o)
      step;
      `CHK("reject one cycle", 1'b0, remap_reject_o)
      rst_n_i = 1'b0;
      step;
      step;
      rst_n_i = 1'b1;
      `CHK("remap over reset pin", 8'h1B, remap_o)
      por_n_i = 1'b0;
      step;
      step;
      por_n_i = 1'b1;
      `CHK("remap after power-on", 8'hE4, remap_o)
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      rst_n_i = 1'b0;
      por_n_i = 1'b0;
      rd_done_i = 1'b0;
      cmd_i = '0;
      chan_evt_i = '0;
      pair_cfg_i = '0;
      repeat (5) @(posedge ref_clk_i);
      #1;
      rst_n_i = 1'b1;
      por_n_i = 1'b1;
      t_reset_values();
      t_fault_codes();
      t_clear_on_read();
      t_pairs();
      t_remap();
      stop_test();
   end

   // Whole run needs under a hundred cycles, so this limit only trips on a hang
   initial
   begin
      #(25 * 5000);
      failures++;
      stop_test();
   end

endmodule // testbench
